//--- core/pio_port_top.sv
// Module: three parallel ports with comparator and pin interrupt inputs
// Operation
// - Narrow port direction set for all lines
// - Wide port direction chosen per line
// - Wide outputs share push-pull or open-drain
// - Input port digital or analog, input only
// - Input lines source interrupts and timer input
// - Requests 0-2 falling edge, 3 rising
// - Analog: two comparators, third line reference
// - Comparator two both edges, one falling
// - Analog: comparators replace pins, first drives timer
// - Comparators off frees reference as digital input
// - Comparators unpowered and ignored during stop; the input port still reads their levels
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/100ps
module pio_port_top (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [pio_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [pio_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [pio_pkg::DATA_W-1:0] reg_rdata_o,
    // Narrow bidirectional port
    input wire logic [2:0] narrow_bidir_port_lines_i,
    output logic [2:0] narrow_bidir_port_lines_o,
    output logic [2:0] narrow_bidir_port_lines_oe_o,
    // Wide bidirectional port
    input wire logic [7:0] wide_bidir_port_lines_i,
    output logic [7:0] wide_bidir_port_lines_o,
    output logic [7:0] wide_bidir_port_lines_oe_o,
    // Input-only port and comparator results
    input wire logic [2:0] input_only_port_lines_i,
    input wire logic first_comparator_out_i,
    input wire logic second_comparator_out_i,
    output logic comparator_power_o,
    output logic analog_mode_o,
    // Core status
    input wire logic stop_mode_i,
    // Results to the core
    output logic timer_external_input_o,
    output logic [3:0] pin_interrupt_requests_o,
    output logic irq_o
);

    typedef struct packed {
        logic [2:0] narrow_data;
        logic narrow_dir_in;
        logic [7:0] wide_data;
        logic [7:0] wide_dir_in;
        logic wide_push_pull;
        logic analog_en;
        logic [3:0] irq_status;
        logic [3:0] irq_mask;
        logic [7:0] rdata;
        logic [2:0] narrow_pin;
        logic [2:0] narrow_oe;
        logic [7:0] wide_pin;
        logic [7:0] wide_oe;
        logic [2:0] input_eff;
        logic [1:0] stop_settle;
        logic cmp_power;
        logic timer_in;
        logic [3:0] req_pulse;
        logic irq;
    } pio_state_t;

    pio_state_t state_q;
    pio_state_t state_d;

    // Synchronised views of every asynchronous input
    pio_edge_if sync_bus ();

    logic [pio_pkg::SYNC_W-1:0] raw_inputs;

    // Pins and comparator results all come from outside this clock
    assign raw_inputs = {second_comparator_out_i,
                         first_comparator_out_i,
                         wide_bidir_port_lines_i,
                         narrow_bidir_port_lines_i,
                         input_only_port_lines_i};

    // Two flops before anything looks at a line
    pio_sync_edge u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .async_i(raw_inputs),
        .edge_o(sync_bus.sync_side)
    );

    // Register address match, shared by the write and read decode
    function automatic logic hit(input logic [pio_pkg::ADDR_W-1:0] addr,
                                 input logic [pio_pkg::ADDR_W-1:0] ofs);
        hit = (addr == ofs);
    endfunction

    // Convenient slices of the synchronised bus
    logic [2:0] in_level;
    logic [2:0] in_rise;
    logic [2:0] in_fall;
    logic [2:0] narrow_level;
    logic [7:0] wide_level;
    logic [1:0] cmp_level;
    logic [1:0] cmp_rise;
    logic [1:0] cmp_fall;

    assign in_level = sync_bus.level[pio_pkg::IN_LSB +: 3];
    assign in_rise = sync_bus.rise[pio_pkg::IN_LSB +: 3];
    assign in_fall = sync_bus.fall[pio_pkg::IN_LSB +: 3];
    assign narrow_level = sync_bus.level[pio_pkg::NARROW_LSB +: 3];
    assign wide_level = sync_bus.level[pio_pkg::WIDE_LSB +: 8];
    assign cmp_level = sync_bus.level[pio_pkg::CMP_LSB +: 2];
    assign cmp_rise = sync_bus.rise[pio_pkg::CMP_LSB +: 2];
    assign cmp_fall = sync_bus.fall[pio_pkg::CMP_LSB +: 2];

    // Comparator edges and the timer input only count when powered and settled
    logic cmp_valid;

    assign cmp_valid = state_q.analog_en && !stop_mode_i &&
                       (state_q.stop_settle == 2'h0);

    // Interrupt request events of this cycle
    logic [3:0] events;

    always_comb begin
        events = 4'h0;
        if (state_q.analog_en) begin
            // Comparator two gives both edges, comparator one falling only
            events[pio_pkg::IRQ_SECOND_FALL] = cmp_valid && cmp_fall[1];
            events[pio_pkg::IRQ_REFERENCE] = cmp_valid && cmp_rise[1];
            events[pio_pkg::IRQ_FIRST_FALL] = cmp_valid && cmp_fall[0];
            events[pio_pkg::IRQ_RISING] = 1'b0;
        end else begin
            // Digital lines: three falling-edge requests, one rising
            events[pio_pkg::IRQ_SECOND_FALL] =
                in_fall[pio_pkg::SECOND_LINE];
            events[pio_pkg::IRQ_REFERENCE] =
                in_fall[pio_pkg::REF_LINE];
            events[pio_pkg::IRQ_FIRST_FALL] =
                in_fall[pio_pkg::FIRST_LINE];
            events[pio_pkg::IRQ_RISING] =
                in_rise[pio_pkg::FIRST_LINE];
        end
    end

    // Next state of the whole block
    always_comb begin
        state_d = state_q;

        // Register writes
        if (reg_write_i) begin
            if (hit(reg_addr_i, pio_pkg::NARROW_DATA_OFS)) begin
                state_d.narrow_data = reg_wdata_i[2:0];
            end
            if (hit(reg_addr_i, pio_pkg::NARROW_DIR_OFS)) begin
                state_d.narrow_dir_in =
                    reg_wdata_i[pio_pkg::NARROW_DIR_IN_BIT];
            end
            if (hit(reg_addr_i, pio_pkg::WIDE_DATA_OFS)) begin
                state_d.wide_data = reg_wdata_i;
            end
            if (hit(reg_addr_i, pio_pkg::WIDE_DIR_OFS)) begin
                state_d.wide_dir_in = reg_wdata_i;
            end
            if (hit(reg_addr_i, pio_pkg::WIDE_DRIVE_OFS)) begin
                state_d.wide_push_pull =
                    reg_wdata_i[pio_pkg::WIDE_PUSH_PULL_BIT];
            end
            if (hit(reg_addr_i, pio_pkg::ANALOG_CTL_OFS)) begin
                state_d.analog_en =
                    reg_wdata_i[pio_pkg::ANALOG_EN_BIT];
            end
            if (hit(reg_addr_i, pio_pkg::IRQ_MASK_OFS)) begin
                state_d.irq_mask = reg_wdata_i[3:0];
            end
        end

        // Read data stands for exactly the cycle after the strobe
        state_d.rdata = 8'h00;
        if (reg_read_i) begin
            case (reg_addr_i)
                pio_pkg::NARROW_DATA_OFS:
                    state_d.rdata = {5'h00, narrow_level};
                pio_pkg::NARROW_DIR_OFS:
                    state_d.rdata = {7'h00, state_q.narrow_dir_in};
                pio_pkg::WIDE_DATA_OFS:
                    state_d.rdata = wide_level;
                pio_pkg::WIDE_DIR_OFS:
                    state_d.rdata = state_q.wide_dir_in;
                pio_pkg::WIDE_DRIVE_OFS:
                    state_d.rdata = {7'h00, state_q.wide_push_pull};
                pio_pkg::INPUT_PORT_OFS:
                    state_d.rdata = {5'h00, state_q.input_eff};
                pio_pkg::ANALOG_CTL_OFS:
                    state_d.rdata = {7'h00, state_q.analog_en};
                pio_pkg::IRQ_STATUS_OFS:
                    state_d.rdata = {4'h0, state_q.irq_status};
                pio_pkg::IRQ_MASK_OFS:
                    state_d.rdata = {4'h0, state_q.irq_mask};
                default:
                    state_d.rdata = 8'h00;
            endcase
        end

        // Sticky status: read clears, a same-cycle event still wins
        if (reg_read_i && hit(reg_addr_i, pio_pkg::IRQ_STATUS_OFS)) begin
            state_d.irq_status = 4'h0;
        end
        state_d.irq_status = state_d.irq_status | events;
        state_d.req_pulse = events;

        // Comparator edges are garbage until power has been back a while
        if (stop_mode_i || !state_q.cmp_power) begin
            state_d.stop_settle = pio_pkg::STOP_SETTLE_CYCLES;
        end else if (state_q.stop_settle != 2'h0) begin
            state_d.stop_settle = state_q.stop_settle - 2'h1;
        end

        // Comparators powered only when enabled and not in stop
        state_d.cmp_power = state_d.analog_en && !stop_mode_i;

        // Effective input port value, the comparators replacing pins
        if (state_q.analog_en) begin
            // Reference line is analog here and reads as zero
            state_d.input_eff[pio_pkg::FIRST_LINE] = cmp_level[0];
            state_d.input_eff[pio_pkg::SECOND_LINE] = cmp_level[1];
            state_d.input_eff[pio_pkg::REF_LINE] = 1'b0;
        end else begin
            state_d.input_eff = in_level;
        end

        // Timer input follows the first line or comparator one
        if (state_q.analog_en) begin
            // Held while the comparator is unpowered
            if (cmp_valid) begin
                state_d.timer_in = cmp_level[0];
            end
        end else begin
            state_d.timer_in = in_level[pio_pkg::FIRST_LINE];
        end

        // Narrow port: one direction bit for all three lines
        state_d.narrow_pin = state_d.narrow_data;
        state_d.narrow_oe = {3{~state_d.narrow_dir_in}};

        // Wide port: open-drain only drives low
        state_d.wide_pin = state_d.wide_data;
        state_d.wide_oe = ~state_d.wide_dir_in &
                          ({8{state_d.wide_push_pull}} |
                           ~state_d.wide_data);

        // Level interrupt from unmasked sticky bits
        state_d.irq = |(state_d.irq_status & state_d.irq_mask);
    end

    // Single register bank; asynchronous reset loads constants only
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q.narrow_data <= pio_pkg::NARROW_DATA_RST;
            state_q.narrow_dir_in <= pio_pkg::NARROW_DIR_IN_RST;
            state_q.wide_data <= pio_pkg::WIDE_DATA_RST;
            state_q.wide_dir_in <= pio_pkg::WIDE_DIR_IN_RST;
            state_q.wide_push_pull <= pio_pkg::WIDE_PUSH_PULL_RST;
            state_q.analog_en <= pio_pkg::ANALOG_EN_RST;
            state_q.irq_status <= pio_pkg::IRQ_STATUS_RST;
            state_q.irq_mask <= pio_pkg::IRQ_MASK_RST;
            state_q.rdata <= pio_pkg::READ_DATA_RST;
            state_q.narrow_pin <= 3'h0;
            state_q.narrow_oe <= 3'h0;
            state_q.wide_pin <= 8'h00;
            state_q.wide_oe <= 8'h00;
            state_q.input_eff <= 3'h0;
            state_q.stop_settle <= 2'h0;
            state_q.cmp_power <= 1'b0;
            state_q.timer_in <= 1'b0;
            state_q.req_pulse <= 4'h0;
            state_q.irq <= 1'b0;
        end else begin
            state_q <= state_d;
        end
    end

    // Outputs straight from the register bank
    assign reg_rdata_o = state_q.rdata;
    assign narrow_bidir_port_lines_o = state_q.narrow_pin;
    assign narrow_bidir_port_lines_oe_o = state_q.narrow_oe;
    assign wide_bidir_port_lines_o = state_q.wide_pin;
    assign wide_bidir_port_lines_oe_o = state_q.wide_oe;
    assign comparator_power_o = state_q.cmp_power;
    assign analog_mode_o = state_q.analog_en;
    assign timer_external_input_o = state_q.timer_in;
    assign pin_interrupt_requests_o = state_q.req_pulse;
    assign irq_o = state_q.irq;

endmodule // pio_port_top

//--- core/pio_pkg.sv
// Package: register map, reset values and event layout of the port block
package pio_pkg;

    // Register bus widths
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [3:0] NARROW_DATA_OFS = 4'h0;
    localparam logic [3:0] NARROW_DIR_OFS = 4'h1;
    localparam logic [3:0] WIDE_DATA_OFS = 4'h2;
    localparam logic [3:0] WIDE_DIR_OFS = 4'h3;
    localparam logic [3:0] WIDE_DRIVE_OFS = 4'h4;
    localparam logic [3:0] INPUT_PORT_OFS = 4'h5;
    localparam logic [3:0] ANALOG_CTL_OFS = 4'h6;
    localparam logic [3:0] IRQ_STATUS_OFS = 4'h7;
    localparam logic [3:0] IRQ_MASK_OFS = 4'h8;

    // Field positions
    localparam int NARROW_DIR_IN_BIT = 0;
    localparam int WIDE_PUSH_PULL_BIT = 0;
    localparam int ANALOG_EN_BIT = 0;

    // Values after reset
    localparam logic [2:0] NARROW_DATA_RST = 3'h0;
    localparam logic NARROW_DIR_IN_RST = 1'b1;
    localparam logic [7:0] WIDE_DATA_RST = 8'h00;
    localparam logic [7:0] WIDE_DIR_IN_RST = 8'hFF;
    localparam logic WIDE_PUSH_PULL_RST = 1'b0;
    localparam logic ANALOG_EN_RST = 1'b0;
    localparam logic [3:0] IRQ_STATUS_RST = 4'h0;
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;
    localparam logic [7:0] READ_DATA_RST = 8'h00;

    // Cycles the comparator edges stay ignored after power returns from stop
    localparam logic [1:0] STOP_SETTLE_CYCLES = 2'h3;

    // Synchronised input vector layout
    localparam int SYNC_W = 16;
    localparam int IN_LSB = 0;
    localparam int NARROW_LSB = 3;
    localparam int WIDE_LSB = 6;
    localparam int CMP_LSB = 14;

    // Input-only line indices
    localparam int FIRST_LINE = 0;
    localparam int SECOND_LINE = 1;
    localparam int REF_LINE = 2;

    // Interrupt request bit positions
    localparam int IRQ_SECOND_FALL = 0;
    localparam int IRQ_REFERENCE = 1;
    localparam int IRQ_FIRST_FALL = 2;
    localparam int IRQ_RISING = 3;

endpackage : pio_pkg

//--- core/pio_edge_if.sv
// Interface: synchronised levels and edge pulses between synchroniser and top
`timescale 1ns/100ps
interface pio_edge_if;
    logic [pio_pkg::SYNC_W-1:0] level;
    logic [pio_pkg::SYNC_W-1:0] rise;
    logic [pio_pkg::SYNC_W-1:0] fall;

    modport sync_side (output level, output rise, output fall);
    modport user_side (input level, input rise, input fall);
endinterface : pio_edge_if

//--- core/pio_sync_edge.sv
// Module: two-stage synchroniser and edge detector for asynchronous inputs
`timescale 1ns/100ps
module pio_sync_edge (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Asynchronous inputs
    input wire logic [pio_pkg::SYNC_W-1:0] async_i,
    // Synchronised results
    pio_edge_if.sync_side edge_o
);

    typedef struct packed {
        logic [pio_pkg::SYNC_W-1:0] meta;
        logic [pio_pkg::SYNC_W-1:0] stable;
        logic [pio_pkg::SYNC_W-1:0] prev;
        logic [2:0] primed;
    } pio_sync_state_t;

    pio_sync_state_t state_q;
    pio_sync_state_t state_d;

    // Shift chain; the meta stage is never examined, stable and prev feed the outputs
    always_comb begin
        state_d = state_q;
        state_d.meta = async_i;
        state_d.stable = state_q.meta;
        state_d.prev = state_q.stable;
        // Chain holds reset zeros for three edges; idle-high pins would
        // otherwise show a false rise right after reset
        state_d.primed = {state_q.primed[1:0], 1'b1};
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // One pulse per edge, since prev follows stable by one cycle
    assign edge_o.level = state_q.stable;
    assign edge_o.rise = state_q.stable & ~state_q.prev &
                         {pio_pkg::SYNC_W{state_q.primed[2]}};
    assign edge_o.fall = ~state_q.stable & state_q.prev &
                         {pio_pkg::SYNC_W{state_q.primed[2]}};

endmodule // pio_sync_edge

//--- tb/pio_far_model.sv
// Far-side model: wide port wiring and the two comparators
`timescale 1ns/100ps
module pio_far_model (
    // Clock
    input wire logic clk_i,
    // Comparator supply, wanted and seen results
    input wire logic pwr_i,
    input wire logic [1:0] cmp_i,
    output logic [1:0] cmp_o,
    // Wide port drive, far-side level and wire level
    input wire logic [7:0] drv_i,
    input wire logic [7:0] oe_i,
    input wire logic [7:0] ext_i,
    output logic [7:0] pin_o
);
    logic flip_q = 1'b0;

    // Unpowered comparators give a changing pattern, never a level
    always @(posedge clk_i) begin
        flip_q <= ~flip_q;
    end
    assign cmp_o = pwr_i ? cmp_i : {flip_q, ~flip_q};
    // Driven lines win; released lines follow the far side
    assign pin_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule // pio_far_model

//--- tb/pio_port_top_props.sv
// Checker: port-level properties of the port block
`timescale 1ns/100ps
module pio_port_top_props (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [pio_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [pio_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_write_i,
    // Port outputs
    input wire logic [2:0] narrow_bidir_port_lines_oe_o,
    input wire logic [7:0] wide_bidir_port_lines_o,
    input wire logic [7:0] wide_bidir_port_lines_oe_o,
    // Input port and comparators
    input wire logic [2:0] input_only_port_lines_i,
    input wire logic second_comparator_out_i,
    input wire logic analog_mode_o,
    input wire logic comparator_power_o,
    input wire logic stop_mode_i,
    // Requests
    input wire logic [3:0] pin_interrupt_requests_o,
    input wire logic irq_o
);
    logic pp_q;
    logic [3:0] mask_q;
    wire [3:0] rq = pin_interrupt_requests_o;
    wire [2:0] ln = input_only_port_lines_i;

    // Shadow of drive mode and mask as last written
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pp_q <= pio_pkg::WIDE_PUSH_PULL_RST;
            mask_q <= pio_pkg::IRQ_MASK_RST;
        end else if (reg_write_i) begin
            if (reg_addr_i == pio_pkg::WIDE_DRIVE_OFS) begin
                pp_q <= reg_wdata_i[0];
            end
            if (reg_addr_i == pio_pkg::IRQ_MASK_OFS) begin
                mask_q <= reg_wdata_i[3:0];
            end
        end
    end

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    // Long enough powered that comparator edges count
    sequence s_cmp_live;
        (analog_mode_o && comparator_power_o)[*8];
    endsequence
    sequence s_stopped;
        (analog_mode_o && stop_mode_i)[*8];
    endsequence

    property p_narrow_dir;
        narrow_bidir_port_lines_oe_o inside {3'h0, 3'h7};
    endproperty
    a_narrow_dir: assert property (p_narrow_dir)
        else $error("narrow enables differ");
    property p_open_drain;
        !pp_q |->
            (wide_bidir_port_lines_o & wide_bidir_port_lines_oe_o) == 8'h00;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open-drain line driven high");
    property p_fall_first;
        !analog_mode_o && $fell(ln[0]) |-> ##[2:5] rq[2];
    endproperty
    a_fall_first: assert property (p_fall_first)
        else $error("first line fall gave no request");
    property p_rise_first;
        !analog_mode_o && $rose(ln[0]) |-> ##[2:5] rq[3];
    endproperty
    a_rise_first: assert property (p_rise_first)
        else $error("first line rise gave no request");
    property p_ref_fall;
        !analog_mode_o && $fell(ln[2]) |-> ##[2:5] rq[1];
    endproperty
    a_ref_fall: assert property (p_ref_fall)
        else $error("reference line fall gave no request");
    property p_cmp2_rise;
        s_cmp_live ##0 $rose(second_comparator_out_i) |-> ##[2:5] rq[1];
    endproperty
    a_cmp2_rise: assert property (p_cmp2_rise)
        else $error("second comparator rise gave no request");
    property p_no_rise_irq;
        analog_mode_o [*6] |-> !rq[3];
    endproperty
    a_no_rise_irq: assert property (p_no_rise_irq)
        else $error("rising request in analog mode");
    property p_stop_quiet;
        s_stopped |-> rq[2:0] == 3'h0;
    endproperty
    a_stop_quiet: assert property (p_stop_quiet)
        else $error("comparator request during stop");
    property p_stop_power;
        stop_mode_i |=> !comparator_power_o;
    endproperty
    a_stop_power: assert property (p_stop_power)
        else $error("comparators powered in stop");
    property p_irq_level;
        (rq & mask_q) != 4'h0 |-> irq_o;
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("unmasked request without irq");
endmodule // pio_port_top_props

bind pio_port_top pio_port_top_props i_pio_port_top_props (.*);

//--- tb/tb_top.sv
// Testbench: stimulus and checks for the port block
`timescale 1ns/100ps
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, w_o, w_oe, w_ext, w_pin, v, d, e;
    logic wr, rd, pwr, ana, stop, tmr, irq;
    logic [2:0] n_o, n_oe, n_ext, n_pin, in_l;
    logic [1:0] cw, cmp;
    logic [3:0] req;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    logic [2:0] dig [4] = '{3'h5, 3'h1, 3'h0, 3'h1};
    logic [1:0] an [4] = '{2'h2, 2'h0, 2'h2, 2'h3};
    logic [7:0] an_irq [4] = '{8'h04, 8'h01, 8'h02, 8'h00};

    // 40 MHz core clock
    always #12.5 clk = ~clk;
    // Narrow wire: driven lines win over the far side
    assign n_pin = (n_oe & n_o) | (~n_oe & n_ext);

    pio_port_top i_pio_port_top (
        .ref_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_write_i(wr), .reg_read_i(rd),
        .reg_rdata_o(rdata), .narrow_bidir_port_lines_i(n_pin),
        .narrow_bidir_port_lines_o(n_o),
        .narrow_bidir_port_lines_oe_o(n_oe),
        .wide_bidir_port_lines_i(w_pin), .wide_bidir_port_lines_o(w_o),
        .wide_bidir_port_lines_oe_o(w_oe), .input_only_port_lines_i(in_l),
        .first_comparator_out_i(cmp[0]), .second_comparator_out_i(cmp[1]),
        .comparator_power_o(pwr), .analog_mode_o(ana), .stop_mode_i(stop),
        .timer_external_input_o(tmr), .pin_interrupt_requests_o(req),
        .irq_o(irq)
    );
    pio_far_model i_pio_far_model (
        .clk_i(clk), .pwr_i(pwr), .cmp_i(cw), .cmp_o(cmp),
        .drv_i(w_o), .oe_i(w_oe), .ext_i(w_ext), .pin_o(w_pin)
    );

    // Open-drain drives only lines whose data is low
    function automatic logic [7:0] exp_oe(logic [7:0] dr, logic [7:0] dt,
                                          logic pp);
        return pp ? ~dr : ~dr & ~dt;
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] dt);
        @(posedge clk);
        addr <= a;
        wdata <= dt;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp,
                          input bit cmp_en);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        if (cmp_en) begin
            chk(rdata, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Hang guard, well above the few hundred cycles needed
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            report_and_stop();
        end
    end

    initial begin
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        n_ext = 3'h5;
        w_ext = 8'h3C;
        in_l = 3'h7;
        cw = 2'h3;
        stop = 1'b0;
        void'($urandom(84));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values; an unmapped write changes nothing
        wr_reg(4'hC, 8'h00);
        rd_reg(pio_pkg::NARROW_DIR_OFS, 8'h01, 1);
        rd_reg(pio_pkg::WIDE_DIR_OFS, 8'hFF, 1);
        rd_reg(pio_pkg::WIDE_DRIVE_OFS, 8'h00, 1);
        rd_reg(pio_pkg::ANALOG_CTL_OFS, 8'h00, 1);
        rd_reg(4'hC, 8'h00, 1);
        rd_reg(pio_pkg::NARROW_DATA_OFS, 8'h05, 1);
        $display("reset test done");
        v = 8'($urandom());
        wr_reg(pio_pkg::NARROW_DATA_OFS, v);
        wr_reg(pio_pkg::NARROW_DIR_OFS, 8'h00);
        chk(8'(n_oe), 8'h07);
        chk(8'(n_o), {5'h0, v[2:0]});
        wr_reg(pio_pkg::NARROW_DIR_OFS, 8'h01);
        chk(8'(n_oe), 8'h00);
        // First pass: all lines out, all high, open-drain
        for (int i = 0; i < 5; i++) begin
            d = (i == 0) ? 8'h00 : 8'($urandom());
            v = (i == 0) ? 8'hFF : 8'($urandom());
            e = exp_oe(d, v, i[0]);
            wr_reg(pio_pkg::WIDE_DIR_OFS, d);
            wr_reg(pio_pkg::WIDE_DATA_OFS, v);
            wr_reg(pio_pkg::WIDE_DRIVE_OFS, {7'h0, i[0]});
            chk(w_oe, e);
            chk(w_o & w_oe, v & e);
            repeat (3) @(posedge clk);
            rd_reg(pio_pkg::WIDE_DATA_OFS, (e & v) | (~e & w_ext), 1);
        end
        $display("port test done");
        wr_reg(pio_pkg::IRQ_MASK_OFS, 8'h0F);
        rd_reg(pio_pkg::IRQ_MASK_OFS, 8'h0F, 1);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            in_l <= dig[k];
            repeat (3) @(posedge clk);
            #1 chk(8'(req), 8'h01 << k);
            repeat (3) @(posedge clk);
            #1 chk(8'(irq), 8'h01);
            chk(8'(tmr), {7'h0, dig[k][0]});
            rd_reg(pio_pkg::IRQ_STATUS_OFS, 8'h01 << k, 1);
            chk(8'(irq), 8'h00);
        end
        // Masked event: status set, no interrupt
        wr_reg(pio_pkg::IRQ_MASK_OFS, 8'h00);
        @(posedge clk);
        in_l <= 3'h7;
        repeat (6) @(posedge clk);
        in_l <= 3'h5;
        repeat (6) @(posedge clk);
        #1 chk(8'(irq), 8'h00);
        rd_reg(pio_pkg::IRQ_STATUS_OFS, 8'h01, 1);
        $display("pin interrupt test done");
        wr_reg(pio_pkg::IRQ_MASK_OFS, 8'h0F);
        wr_reg(pio_pkg::ANALOG_CTL_OFS, 8'h01);
        repeat (8) @(posedge clk);
        #1 chk({6'h0, pwr, ana}, 8'h03);
        rd_reg(pio_pkg::IRQ_STATUS_OFS, 8'h00, 1);
        // Pin edges must be ignored while comparators rule
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            cw <= an[k];
            in_l <= 3'(k);
            repeat (6) @(posedge clk);
            #1 chk(8'(tmr), {7'h0, an[k][0]});
            rd_reg(pio_pkg::INPUT_PORT_OFS, {6'h0, an[k]}, 1);
            rd_reg(pio_pkg::IRQ_STATUS_OFS, an_irq[k], 1);
        end
        @(posedge clk);
        stop <= 1'b1;
        repeat (12) @(posedge clk);
        #1 chk(8'(pwr), 8'h00);
        rd_reg(pio_pkg::IRQ_STATUS_OFS, 8'h00, 1);
        @(posedge clk);
        stop <= 1'b0;
        repeat (12) @(posedge clk);
        rd_reg(pio_pkg::IRQ_STATUS_OFS, 8'h00, 1);
        $display("analog test done");
        wr_reg(pio_pkg::ANALOG_CTL_OFS, 8'h00);
        repeat (6) @(posedge clk);
        rd_reg(pio_pkg::IRQ_STATUS_OFS, 8'h00, 1);
        @(posedge clk);
        in_l <= 3'h7;
        repeat (6) @(posedge clk);
        in_l <= 3'h3;
        repeat (6) @(posedge clk);
        rd_reg(pio_pkg::IRQ_STATUS_OFS, 8'h02, 1);
        rd_reg(pio_pkg::INPUT_PORT_OFS, 8'h03, 1);
        $display("reference release test done");
        report_and_stop();
    end
endmodule // tb_top
